// >>> src/dci_pkg.sv
// Functional notes
// - Trim launch enters diagnostics, starts routine, if permitted.
// - Trim launch: option digit, routine digit, step.
// - Execute runs selected routine, like panel button.
// - Repeat control sets looping; no argument means ON.
// - Repeat query answers looping header plus ON/OFF.
// - Leave diagnostics returns normal; no-op when normal.
// - Advance phase moves running routine to next step.
// - Phase query answers step header plus step number.
// - Abort ends running routine, stays in diagnostics.
// - Sequence select takes option and routine number.
// - Run check executes test, answers status; zero passes.
package dci_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_ADDR   = 8'h00; // Command word, write only
  localparam logic [7:0] STAT_ADDR  = 8'h04; // Mode and engine state
  localparam logic [7:0] RESP_ADDR  = 8'h08; // Query answer, read clears valid
  localparam logic [7:0] ISTAT_ADDR = 8'h0C; // Sticky event bits
  localparam logic [7:0] ICLR_ADDR  = 8'h10; // Write one to clear
  localparam logic [7:0] IEN_ADDR   = 8'h14; // Event enables

  // ----------------------------------------------------------------
  // Command word layout
  // ----------------------------------------------------------------
  localparam int OPC_LSB   = 0;  // Opcode field
  localparam int OPC_W     = 4;
  localparam int OPT_LSB   = 4;  // Leading digit: option
  localparam int RTN_LSB   = 8;  // Next digit: routine
  localparam int DIGIT_W   = 4;
  localparam int STEP_LSB  = 12; // Step argument
  localparam int STEP_W    = 8;
  localparam int ARGP_BIT  = 20; // Argument present flag
  localparam int ARGV_BIT  = 21; // ON/OFF argument value

  // Opcodes
  localparam logic [3:0] OP_CAL  = 4'h1; // Trim routine launch
  localparam logic [3:0] OP_GO   = 4'h2; // Execute selected routine
  localparam logic [3:0] OP_LSET = 4'h3; // Repeat test control
  localparam logic [3:0] OP_LQRY = 4'h4; // Repeat test query
  localparam logic [3:0] OP_NORM = 4'h5; // Leave diagnostics
  localparam logic [3:0] OP_STEP = 4'h6; // Advance phase
  localparam logic [3:0] OP_SQRY = 4'h7; // Phase number query
  localparam logic [3:0] OP_STOP = 4'h8; // Abort routine
  localparam logic [3:0] OP_TSEL = 4'h9; // Sequence select
  localparam logic [3:0] OP_TQRY = 4'hA; // Run check query

  // ----------------------------------------------------------------
  // Answer word layout and headers
  // ----------------------------------------------------------------
  localparam int HDR_LSB = 28;
  localparam logic [3:0] HDR_LOOP = 4'h1;
  localparam logic [3:0] HDR_STEP = 4'h2;
  localparam logic [3:0] HDR_TEST = 4'h3;

  // Interrupt event bits
  localparam int NUM_EV  = 3;
  localparam int EV_ERR  = 0; // Command refused
  localparam int EV_RESP = 1; // Answer ready
  localparam int EV_DONE = 2; // Routine finished

  localparam logic [7:0] STEP_ONE = 8'h01;

  typedef enum logic [1:0] { ST_IDLE, ST_RUN, ST_QUERY } dci_state_e;

endpackage

// >>> src/dci_irq_if.sv
`timescale 1ns/1ns
// Carries events and software access between core and interrupt bank
interface dci_irq_if;
  logic [dci_pkg::NUM_EV-1:0] ev_set;   // One-cycle event pulses
  logic [dci_pkg::NUM_EV-1:0] clr_mask; // Clear bits, valid with clr_wr
  logic                       clr_wr;   // Clear register write
  logic                       en_wr;    // Enable register write
  logic [dci_pkg::NUM_EV-1:0] en_data;  // Enable value
  logic [dci_pkg::NUM_EV-1:0] status;   // Sticky status
  logic [dci_pkg::NUM_EV-1:0] enable;   // Current enables

  modport core (output ev_set, clr_mask, clr_wr, en_wr, en_data, input status, enable);
  modport bank (input ev_set, clr_mask, clr_wr, en_wr, en_data, output status, enable);
endinterface

// >>> src/dci_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for pin levels
module dci_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q; // First stage, read only by second stage

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // dci_sync

// >>> src/dci_irq.sv
`timescale 1ns/1ns
// Sticky event status, enables and level interrupt
module dci_irq (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // Core side
  dci_irq_if.bank   ifc,
  // Interrupt line
  output logic      irq
);
  logic [dci_pkg::NUM_EV-1:0] stat_q; // Sticky bits
  logic [dci_pkg::NUM_EV-1:0] en_q;   // Enables

  assign ifc.status = stat_q;
  assign ifc.enable = en_q;

  // Set beats clear so an event in the clear cycle is kept
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      stat_q <= '0;
    else if (ifc.clr_wr)
      stat_q <= (stat_q & ~ifc.clr_mask) | ifc.ev_set;
    else
      stat_q <= stat_q | ifc.ev_set;
  end

  // Enable register
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      en_q <= '0;
    else if (ifc.en_wr)
      en_q <= ifc.en_data;
  end

  // Level output from a flop
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(stat_q & en_q);
  end
endmodule // dci_irq

// >>> src/dci_core.sv
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ns
// Diagnostic command interpreter: command decode, mode flag and
// routine engine control.
module dci_core (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  // Pins
  input  wire logic        trim_permit_pin,
  input  wire logic        panel_go_pin,
  // Routine engine
  output logic             rtn_start,
  output logic             rtn_is_test,
  output logic      [3:0]  rtn_option,
  output logic      [3:0]  rtn_routine,
  output logic      [7:0]  rtn_step,
  output logic             rtn_advance,
  output logic             rtn_abort,
  output logic             loop_en,
  output logic             diag_mode,
  input  wire logic        rtn_done,
  input  wire logic [7:0]  rtn_status,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                   permit;      // Synchronised jumper level
  logic                   panel_lvl;   // Synchronised button level
  logic                   panel_d_q;   // Previous button level
  logic                   panel_rise;  // Button press
  dci_pkg::dci_state_e    state_q;     // Engine tracking state
  logic                   sel_valid_q; // A routine has been selected
  logic                   resp_vld_q;  // Answer waiting to be read
  logic [31:0]            resp_q;      // Answer word
  logic                   cmd_wr;      // Command register written
  logic [3:0]             opc;         // Decoded opcode
  logic [3:0]             arg_opt;     // Option digit
  logic [3:0]             arg_rtn;     // Routine digit
  logic [7:0]             arg_step;    // Step argument
  logic                   do_cal;
  logic                   do_go;
  logic                   do_lset;
  logic                   do_lqry;
  logic                   do_norm;
  logic                   do_step;
  logic                   do_sqry;
  logic                   do_stop;
  logic                   do_tsel;
  logic                   do_tqry;
  logic                   cmd_bad;     // Refused or unknown command
  logic                   launch;      // Start the routine this cycle
  logic                   done_run;    // Engine finished a routine
  logic                   resp_set;    // New answer this cycle
  logic [31:0]            resp_d;      // New answer word

  dci_irq_if irq_bus ();

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  dci_sync #(.W(2)) u_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in ({trim_permit_pin, panel_go_pin}),
    .sync_out ({permit, panel_lvl})
  );

  // Edge detect works on the settled level only
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      panel_d_q <= 1'b0;
    else
      panel_d_q <= panel_lvl;
  end

  assign panel_rise = panel_lvl & ~panel_d_q;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign cmd_wr   = bus_wr && (bus_addr == dci_pkg::CMD_ADDR);
  assign opc      = bus_wdata[dci_pkg::OPC_LSB +: dci_pkg::OPC_W];
  assign arg_opt  = bus_wdata[dci_pkg::OPT_LSB +: dci_pkg::DIGIT_W];
  assign arg_rtn  = bus_wdata[dci_pkg::RTN_LSB +: dci_pkg::DIGIT_W];
  assign arg_step = bus_wdata[dci_pkg::STEP_LSB +: dci_pkg::STEP_W];

  // Acceptance; a pending test answer blocks most commands
  always_comb
  begin
    do_cal  = cmd_wr && (opc == dci_pkg::OP_CAL) && permit
              && (state_q == dci_pkg::ST_IDLE);
    do_go   = (cmd_wr && (opc == dci_pkg::OP_GO) || panel_rise)
              && diag_mode && sel_valid_q
              && (state_q == dci_pkg::ST_IDLE);
    do_lset = cmd_wr && (opc == dci_pkg::OP_LSET);
    do_lqry = cmd_wr && (opc == dci_pkg::OP_LQRY) && (state_q != dci_pkg::ST_QUERY);
    do_norm = cmd_wr && (opc == dci_pkg::OP_NORM) && (state_q != dci_pkg::ST_QUERY);
    do_step = cmd_wr && (opc == dci_pkg::OP_STEP) && (state_q == dci_pkg::ST_RUN);
    do_sqry = cmd_wr && (opc == dci_pkg::OP_SQRY) && (state_q != dci_pkg::ST_QUERY);
    do_stop = cmd_wr && (opc == dci_pkg::OP_STOP) && (state_q != dci_pkg::ST_IDLE);
    do_tsel = cmd_wr && (opc == dci_pkg::OP_TSEL) && (state_q == dci_pkg::ST_IDLE);
    do_tqry = cmd_wr && (opc == dci_pkg::OP_TQRY) && (state_q == dci_pkg::ST_IDLE);
    // Anything written but not taken is reported
    cmd_bad = cmd_wr && !(do_cal || do_lset || do_lqry || do_norm || do_step
              || do_sqry || do_stop || do_tsel || do_tqry
              || ((opc == dci_pkg::OP_GO) && do_go));
  end

  assign launch   = do_cal || do_go || do_tqry;
  assign done_run = rtn_done && (state_q != dci_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // Diagnostic mode flag
  // ----------------------------------------------------------------
  // Leaving mid-run also aborts; in normal mode a no-op
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      diag_mode <= 1'b0;
    else if (do_cal || do_tsel || do_tqry)
      diag_mode <= 1'b1;
    else if (do_norm)
      diag_mode <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Routine selection
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_valid_q <= 1'b0;
      rtn_is_test <= 1'b0;
      rtn_option  <= 4'h0;
      rtn_routine <= 4'h0;
    end
    else if (do_cal)
    begin
      // Calibration: option and routine from the first argument
      sel_valid_q <= 1'b1;
      rtn_is_test <= 1'b0;
      rtn_option  <= arg_opt;
      rtn_routine <= arg_rtn;
    end
    else if (do_tsel || do_tqry)
    begin
      // Test sequence shares the option numbering
      sel_valid_q <= 1'b1;
      rtn_is_test <= 1'b1;
      rtn_option  <= arg_opt;
      rtn_routine <= arg_rtn;
    end
  end

  // ----------------------------------------------------------------
  // Step number
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rtn_step <= 8'h00;
    else if (do_cal)
      rtn_step <= arg_step;
    else if (do_tsel || do_tqry)
      rtn_step <= 8'h00;
    else if (do_step)
      rtn_step <= rtn_step + dci_pkg::STEP_ONE;
  end

  // ----------------------------------------------------------------
  // Looping setting
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      loop_en <= 1'b0;
    else if (do_lset)
      // Missing argument means ON
      loop_en <= !bus_wdata[dci_pkg::ARGP_BIT] || bus_wdata[dci_pkg::ARGV_BIT];
  end

  // ----------------------------------------------------------------
  // Engine tracking state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      state_q <= dci_pkg::ST_IDLE;
    else
    begin
      case (state_q)
        dci_pkg::ST_IDLE:
        begin
          if (do_tqry)
            state_q <= dci_pkg::ST_QUERY;
          else if (do_cal || do_go)
            state_q <= dci_pkg::ST_RUN;
        end
        dci_pkg::ST_RUN:
        begin
          // Abort and leave take priority over a finish
          if (do_stop || do_norm)
            state_q <= dci_pkg::ST_IDLE;
          else if (done_run && !loop_en)
            state_q <= dci_pkg::ST_IDLE;
        end
        dci_pkg::ST_QUERY:
        begin
          if (do_stop || done_run)
            state_q <= dci_pkg::ST_IDLE;
        end
        default:
          state_q <= dci_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Engine strobes
  // ----------------------------------------------------------------
  // A looping run restarts on finish unless aborted that cycle
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rtn_start   <= 1'b0;
      rtn_advance <= 1'b0;
      rtn_abort   <= 1'b0;
    end
    else
    begin
      rtn_start   <= launch || ((state_q == dci_pkg::ST_RUN) && done_run
                     && loop_en && !do_stop && !do_norm);
      rtn_advance <= do_step;
      rtn_abort   <= do_stop || (do_norm && (state_q == dci_pkg::ST_RUN));
    end
  end

  // ----------------------------------------------------------------
  // Query answers
  // ----------------------------------------------------------------
  always_comb
  begin
    resp_set = 1'b0;
    resp_d   = resp_q;
    if ((state_q == dci_pkg::ST_QUERY) && done_run)
    begin
      resp_set = 1'b1;
      resp_d   = {dci_pkg::HDR_TEST, 20'h00000, rtn_status};
    end
    else if (do_lqry)
    begin
      resp_set = 1'b1;
      resp_d   = {dci_pkg::HDR_LOOP, 27'h0000000, loop_en};
    end
    else if (do_sqry)
    begin
      resp_set = 1'b1;
      resp_d   = {dci_pkg::HDR_STEP, 20'h00000, rtn_step};
    end
  end

  // Answer word
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      resp_q <= 32'h00000000;
    else if (resp_set)
      resp_q <= resp_d;
  end

  // Valid flag: a new answer wins over the read that clears it
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      resp_vld_q <= 1'b0;
    else if (resp_set)
      resp_vld_q <= 1'b1;
    else if (bus_rd && (bus_addr == dci_pkg::RESP_ADDR))
      resp_vld_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Interrupt bank
  // ----------------------------------------------------------------
  assign irq_bus.ev_set[dci_pkg::EV_ERR]  = cmd_bad;
  assign irq_bus.ev_set[dci_pkg::EV_RESP] = resp_set;
  assign irq_bus.ev_set[dci_pkg::EV_DONE] = done_run;
  assign irq_bus.clr_wr   = bus_wr && (bus_addr == dci_pkg::ICLR_ADDR);
  assign irq_bus.clr_mask = bus_wdata[dci_pkg::NUM_EV-1:0];
  assign irq_bus.en_wr    = bus_wr && (bus_addr == dci_pkg::IEN_ADDR);
  assign irq_bus.en_data  = bus_wdata[dci_pkg::NUM_EV-1:0];

  dci_irq u_irq (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .ifc     (irq_bus.bank),
    .irq     (irq)
  );

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe and zero otherwise
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      bus_rdata <= 32'h00000000;
    else if (bus_rd)
    begin
      case (bus_addr)
        dci_pkg::STAT_ADDR:
          bus_rdata <= {16'h0000, rtn_step, 1'b0, rtn_is_test, permit,
                        resp_vld_q, loop_en, (state_q != dci_pkg::ST_IDLE),
                        sel_valid_q, diag_mode};
        dci_pkg::RESP_ADDR:
          bus_rdata <= resp_q;
        dci_pkg::ISTAT_ADDR:
          bus_rdata <= {29'h00000000, irq_bus.status};
        dci_pkg::IEN_ADDR:
          bus_rdata <= {29'h00000000, irq_bus.enable};
        // Command and clear registers are write only
        default:
          bus_rdata <= 32'h00000000;
      endcase
    end
    else
      bus_rdata <= 32'h00000000;
  end

endmodule // dci_core

// >>> testbench/dci_core_sva.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Port checks for the command interpreter
// ------------------------------------------------------------
module dci_core_sva (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // Register port
  input wire logic [7:0]  bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_rdata,
  // Pins
  input wire logic        trim_permit_pin,
  input wire logic        panel_go_pin,
  // Routine engine
  input wire logic        rtn_start,
  input wire logic        rtn_is_test,
  input wire logic [3:0]  rtn_option,
  input wire logic [3:0]  rtn_routine,
  input wire logic [7:0]  rtn_step,
  input wire logic        rtn_advance,
  input wire logic        rtn_abort,
  input wire logic        loop_en,
  input wire logic        diag_mode,
  input wire logic        rtn_done,
  input wire logic [7:0]  rtn_status,
  // Interrupt
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Command word of one opcode taken on this edge
  sequence s_cmd(logic [3:0] op);
    bus_wr && bus_addr == dci_pkg::CMD_ADDR && bus_wdata[3:0] == op;
  endsequence
  // Jumper off long enough to clear the synchroniser
  sequence s_no_permit;
    !trim_permit_pin [*3];
  endsequence
  a_start_in_diag: assert property (rtn_start |-> diag_mode)
    else $error("routine started outside diagnostic mode");
  a_cal_fields: assert property (s_cmd(dci_pkg::OP_CAL) ##1 rtn_start |->
    rtn_step == $past(bus_wdata[19:12]) && rtn_option == $past(bus_wdata[7:4])
    && rtn_routine == $past(bus_wdata[11:8]) && !rtn_is_test)
    else $error("launch arguments not applied");
  a_adv_step: assert property (rtn_advance |-> rtn_step == $past(rtn_step) + 8'h01)
    else $error("advance did not add one step");
  a_adv_norm: assert property (s_cmd(dci_pkg::OP_STEP) ##0 !diag_mode |=> !rtn_advance)
    else $error("advance outside diagnostic mode");
  a_loop_set: assert property (s_cmd(dci_pkg::OP_LSET) |=>
    loop_en == (!$past(bus_wdata[20]) || $past(bus_wdata[21])))
    else $error("looping setting wrong");
  a_loop_again: assert property (rtn_done && loop_en && !rtn_is_test && !bus_wr |=> rtn_start)
    else $error("looping did not relaunch");
  a_leave_exit: assert property (s_cmd(dci_pkg::OP_NORM) ##0 !rtn_is_test |=> !diag_mode)
    else $error("leave kept diagnostic mode");
  a_abort_diag: assert property (s_cmd(dci_pkg::OP_STOP) ##0 diag_mode |=> diag_mode)
    else $error("abort left diagnostic mode");
  a_deny_mode: assert property (s_no_permit ##0 s_cmd(dci_pkg::OP_CAL) ##0 !diag_mode
    |=> !diag_mode && !rtn_start)
    else $error("launch taken without permit");
  a_test_nostart: assert property (s_cmd(dci_pkg::OP_TSEL) ##0 !rtn_done |=> !rtn_start)
    else $error("test select started a routine");
endmodule // dci_core_sva

bind dci_core dci_core_sva u_sva (.sys_clk(sys_clk), .resetn(resetn), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .trim_permit_pin(trim_permit_pin), .panel_go_pin(panel_go_pin), .rtn_start(rtn_start),
  .rtn_is_test(rtn_is_test), .rtn_option(rtn_option), .rtn_routine(rtn_routine),
  .rtn_step(rtn_step), .rtn_advance(rtn_advance), .rtn_abort(rtn_abort), .loop_en(loop_en),
  .diag_mode(diag_mode), .rtn_done(rtn_done), .rtn_status(rtn_status), .irq(irq));

// >>> testbench/dci_engine_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Routine engine stand-in: runs for lat cycles, then reports
// ------------------------------------------------------------
module dci_engine_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Requests from the interpreter
  input  wire logic       rtn_start,
  input  wire logic       rtn_abort,
  // Behaviour chosen by the bench
  input  wire logic [7:0] lat,
  input  wire logic [7:0] code,
  // Completion
  output logic            rtn_done,
  output logic      [7:0] rtn_status
);
  logic [7:0] cnt_q; // Cycles left, zero when idle
  // Countdown; an abort kills the pending completion
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q    <= 8'h00;
      rtn_done <= 1'b0;
    end
    else
    begin
      rtn_done <= (cnt_q == 8'h01) && !rtn_abort;
      if (rtn_abort)
        cnt_q <= 8'h00;
      else if (rtn_start)
        cnt_q <= lat;
      else if (cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
    end
  end
  // Status is valid only beside done; scrambled otherwise
  assign rtn_status = rtn_done ? code : ~code;
endmodule // dci_engine_model

// >>> testbench/test_diag_command_interpreter.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Self-checking bench for the command interpreter
// ------------------------------------------------------------
module test_diag_command_interpreter;
  logic        sys_clk = 1'b0;  // 20 MHz clock
  logic        resetn = 1'b0;   // Reset, active low
  logic [7:0]  bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  logic        permit = 1'b0;   // Trim jumper
  logic        panel = 1'b0;    // Execute button
  logic        rtn_start, rtn_is_test, rtn_advance, rtn_abort, loop_en, diag_mode, irq;
  logic        rtn_done, seen;
  logic [3:0]  rtn_option, rtn_routine;
  logic [7:0]  rtn_step, rtn_status;
  logic [7:0]  lat = 8'h14;     // Engine run time
  logic [7:0]  code = 8'h00;    // Engine result
  logic [31:0] rd_q;            // Last read data
  int          mismatches = 0;
  int          tests_run = 0;
  always #25 sys_clk = ~sys_clk;
  dci_core uut (.sys_clk(sys_clk), .resetn(resetn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .trim_permit_pin(permit), .panel_go_pin(panel), .rtn_start(rtn_start),
    .rtn_is_test(rtn_is_test), .rtn_option(rtn_option), .rtn_routine(rtn_routine),
    .rtn_step(rtn_step), .rtn_advance(rtn_advance), .rtn_abort(rtn_abort), .loop_en(loop_en),
    .diag_mode(diag_mode), .rtn_done(rtn_done), .rtn_status(rtn_status), .irq(irq));
  dci_engine_model u_eng (.sys_clk(sys_clk), .resetn(resetn), .rtn_start(rtn_start),
    .rtn_abort(rtn_abort), .lat(lat), .code(code), .rtn_done(rtn_done), .rtn_status(rtn_status));
  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic chk(string name, logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Write; returns just after the taking edge
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    #1;
  endtask
  task automatic cmd(logic [31:0] d);
    wr(dci_pkg::CMD_ADDR, d);
  endtask
  // Read; data stand only in the next cycle
  task automatic rd(logic [7:0] a);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 rd_q = bus_rdata;
  endtask
  // Bounded wait for done, then one edge
  task automatic wait_done();
    int i = 0;
    while (rtn_done !== 1'b1 && i < 100)
    begin
      @(posedge sys_clk);
      #1 i++;
    end
    chk("done", rtn_done, 1);
    @(posedge sys_clk);
    #1;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_deny();
    rd(dci_pkg::STAT_ADDR);
    chk("stat reset", rd_q, 0);
    rd(8'h20);
    chk("unmapped", rd_q, 0);
    cmd(32'h7531);
    chk("deny start", {diag_mode, rtn_start}, 0);
    rd(dci_pkg::ISTAT_ADDR);
    chk("deny err", rd_q[0], 1);
    wr(dci_pkg::IEN_ADDR, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk("irq on", irq, 1);
    wr(dci_pkg::ICLR_ADDR, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk("irq off", irq, 0);
  endtask
  task automatic t_cal();
    @(posedge sys_clk);
    permit <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cmd(32'h7531);
    chk("launch", {diag_mode, rtn_start, rtn_option, rtn_routine, rtn_step}, 'h33507);
    cmd(dci_pkg::OP_STEP);
    chk("advance", {rtn_advance, rtn_step}, 'h108);
    cmd(dci_pkg::OP_SQRY);
    rd(dci_pkg::RESP_ADDR);
    chk("step answer", rd_q, 32'h2000_0008);
    cmd(dci_pkg::OP_STOP);
    chk("abort", {rtn_abort, diag_mode}, 'h3);
    cmd(dci_pkg::OP_GO);
    chk("execute", rtn_start, 1);
    cmd(dci_pkg::OP_STOP);
    @(posedge sys_clk);
    panel <= 1'b1;
    seen = 1'b0;
    repeat (6)
    begin
      @(posedge sys_clk);
      #1 seen = seen | rtn_start;
    end
    panel <= 1'b0;
    chk("panel go", seen, 1);
    cmd(dci_pkg::OP_STOP);
  endtask
  task automatic t_loop();
    cmd(32'h3);
    chk("loop default", loop_en, 1);
    cmd(dci_pkg::OP_LQRY);
    rd(dci_pkg::RESP_ADDR);
    chk("loop answer on", rd_q, 32'h1000_0001);
    cmd(dci_pkg::OP_GO);
    wait_done();
    chk("relaunch", rtn_start, 1);
    cmd(dci_pkg::OP_STOP);
    cmd(32'h0010_0003);
    chk("loop off", loop_en, 0);
    cmd(dci_pkg::OP_LQRY);
    rd(dci_pkg::RESP_ADDR);
    chk("loop answer off", rd_q, 32'h1000_0000);
  endtask
  // Leave is sent twice, then an advance that must be refused
  task automatic t_leave();
    cmd(dci_pkg::OP_NORM);
    chk("leave", diag_mode, 0);
    cmd(dci_pkg::OP_NORM);
    rd(dci_pkg::ISTAT_ADDR);
    chk("leave idle", {diag_mode, rd_q[0]}, 0);
    cmd(dci_pkg::OP_STEP);
    chk("step refused", rtn_advance, 0);
  endtask
  task automatic t_test();
    @(posedge sys_clk);
    lat  <= 8'h03;
    code <= 8'h05;
    cmd(32'h429);
    chk("select", {diag_mode, rtn_is_test, rtn_start, rtn_option, rtn_routine}, 'h624);
    cmd(32'h42A);
    chk("check start", rtn_start, 1);
    wait_done();
    rd(dci_pkg::RESP_ADDR);
    chk("test fail", rd_q, 32'h3000_0005);
    code <= 8'h00;
    cmd(32'h42A);
    wait_done();
    rd(dci_pkg::RESP_ADDR);
    chk("test pass", rd_q, 32'h3000_0000);
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    t_deny();
    t_cal();
    t_loop();
    t_leave();
    t_test();
    summarize();
  end
  // Watchdog: the run needs under two hundred cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end
endmodule // test_diag_command_interpreter
